/* design/vcht_timing.sv */
`timescale 1ns/1ps
// Operation
// - Horizontal sync starts when the character counter reaches the 8-bit sync start value.
// - The effective sync start moves with the sync skew setting and with text or graphics mode.
// - The 6-bit blanking end is sync end register bit 7 over the five low blanking end bits.
// - Both edges of sync are delayed by 0 to 3 character clocks as sync end bits 6:5 say, plus one more in text mode.
// - Retrace goes low when the low five counter bits equal the 5-bit sync end field.
// - In standard modes the vertical total is 10 bits: low byte register plus two overflow bits.
// - The vertical total plus 2 gives every scan line of a frame, active or not, in 10 or 12 bits.
// - Vertical total bit 9 is overflow bit 5 and bit 8 is overflow bit 0.
module vcht_timing (
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire vcht_pkg::vcht_cpu_req_t cpu_req,
	output logic [7:0]                  cpu_rdata,
	input  wire logic                   char_clk_en,
	input  wire logic                   line_start,
	input  wire logic                   text_mode,
	input  wire logic [4:0]             horiz_blank_end_low,
	input  wire logic [7:0]             vertical_overflow,
	input  wire logic                   vt_ext_mode,
	input  wire logic [1:0]             vt_ext_bits,
	output logic [5:0]                  horiz_blank_end,
	output logic [11:0]                 vert_total,
	output logic [7:0]                  hchar_count,
	output logic [11:0]                 scan_line,
	output logic                        frame_start,
	output logic                        hretrace
);
	import vcht_pkg::*;

	// Delay line must reach the largest skew plus the text extra
	if (MAX_DELAY < 3 + int'(TEXT_EXTRA)) begin : g_delay_fit
		$error("delay line shorter than largest sync delay");
	end

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0]          horiz_sync_start_ff;
	logic [7:0]          horiz_sync_end_ff;
	logic [7:0]          vert_total_low_ff;
	logic [7:0]          rdata_ff;
	logic [HCOUNT_W-1:0] hcount_ff;
	logic [VCOUNT_W-1:0] vcount_ff;
	logic                frame_start_ff;
	logic                raw_retrace_ff;
	logic [MAX_DELAY-1:0] delay_pipe_ff;
	logic                hretrace_ff;
	logic [5:0]          hblank_end_ff;
	logic [11:0]         vtotal_ff;

	// ----------------------------------------------------------------
	// Decode and next values
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
		hit = (idx == want);
	endfunction

	wire logic                wr_start  = cpu_req.wr && hit(cpu_req.index, IDX_HSYNC_START);
	wire logic                wr_end    = cpu_req.wr && hit(cpu_req.index, IDX_HSYNC_END);
	wire logic                wr_vtot   = cpu_req.wr && hit(cpu_req.index, IDX_VTOTAL_LOW);
	wire logic [1:0]          sync_delay = horiz_sync_end_ff[HEND_DELAY_HI:HEND_DELAY_LO];
	wire logic [4:0]          sync_end  = horiz_sync_end_ff[HEND_SYNC_HI:0];
	wire logic                start_hit = (hcount_ff == horiz_sync_start_ff);
	wire logic                end_hit   = (hcount_ff[4:0] == sync_end);
	wire logic [2:0]          eff_delay = {1'b0, sync_delay} + (text_mode ? TEXT_EXTRA : 3'h0);
	wire logic [MAX_DELAY:0]  taps      = {delay_pipe_ff, raw_retrace_ff}; // Tap 0 is raw level
	wire logic [HCOUNT_W-1:0] nxt_hcount = line_start ? '0 : hcount_ff + 1'b1;
	wire logic                last_line = (vcount_ff == vtotal_ff + VTOTAL_ADJUST);
	wire logic [VCOUNT_W-1:0] nxt_vcount = last_line ? '0 : vcount_ff + 1'b1;
	wire logic [11:0]         nxt_vtotal = {vt_ext_mode ? vt_ext_bits : 2'h0,
		vertical_overflow[OVF_VTOTAL_B9], vertical_overflow[OVF_VTOTAL_B8],
		vert_total_low_ff};
	wire logic [7:0]          nxt_rdata =
		hit(cpu_req.index, IDX_HSYNC_START) ? horiz_sync_start_ff :
		hit(cpu_req.index, IDX_HSYNC_END)   ? horiz_sync_end_ff :
		hit(cpu_req.index, IDX_VTOTAL_LOW)  ? vert_total_low_ff : 8'h00;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			horiz_sync_start_ff <= RST_HSYNC_START;
			horiz_sync_end_ff   <= RST_HSYNC_END;
			vert_total_low_ff   <= RST_VTOTAL_LOW;
			rdata_ff            <= 8'h00;
		end else begin
			if (wr_start) horiz_sync_start_ff <= cpu_req.wdata;
			if (wr_end)   horiz_sync_end_ff   <= cpu_req.wdata;
			if (wr_vtot)  vert_total_low_ff   <= cpu_req.wdata;
			if (cpu_req.rd) rdata_ff <= nxt_rdata;
		end
	end

	// Derived timing values
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hblank_end_ff <= 6'h00;
			vtotal_ff     <= 12'h000;
		end else begin
			hblank_end_ff <= {horiz_sync_end_ff[HEND_BLANK_B5], horiz_blank_end_low};
			vtotal_ff     <= nxt_vtotal;
		end
	end

	// Character and scan line counters
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			hcount_ff      <= '0;
			vcount_ff      <= '0;
			frame_start_ff <= 1'b0;
		end else begin
			if (char_clk_en) hcount_ff <= nxt_hcount;
			if (char_clk_en && line_start) vcount_ff <= nxt_vcount;
			frame_start_ff <= char_clk_en && line_start && last_line;
		end
	end

	// Undelayed retrace level, set wins over clear
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			raw_retrace_ff <= 1'b0;
		end else if (char_clk_en) begin
			if (start_hit) raw_retrace_ff <= 1'b1;
			else if (end_hit) raw_retrace_ff <= 1'b0;
		end
	end

	// Delay line for both sync edges
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			delay_pipe_ff <= '0;
			hretrace_ff   <= 1'b0;
		end else begin
			if (char_clk_en) delay_pipe_ff <= {delay_pipe_ff[MAX_DELAY-2:0], raw_retrace_ff};
			hretrace_ff <= taps[eff_delay];
		end
	end

	assign cpu_rdata       = rdata_ff;
	assign horiz_blank_end = hblank_end_ff;
	assign vert_total      = vtotal_ff;
	assign hchar_count     = hcount_ff;
	assign scan_line       = vcount_ff;
	assign frame_start     = frame_start_ff;
	assign hretrace        = hretrace_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_start_char;
		char_clk_en && start_hit;
	endsequence

	sequence s_end_char;
		char_clk_en && end_hit && !start_hit;
	endsequence

	// Raw retrace level and the delay line feeding it out
	chk_sync_set_start: assert property (s_start_char |=> raw_retrace_ff)
		else $error("retrace not set at sync start");
	chk_sync_end_clear: assert property (s_end_char |=> !raw_retrace_ff)
		else $error("retrace not cleared at sync end");
	chk_pipe_shift_in: assert property (char_clk_en
		|=> delay_pipe_ff[0] == $past(raw_retrace_ff))
		else $error("delay line did not take raw retrace");
	chk_pipe_hold_idle: assert property (!char_clk_en
		|=> $stable(delay_pipe_ff))
		else $error("delay line moved without character clock");

	// Blanking end assembly
	chk_blank_end_form: assert property (1 |=> horiz_blank_end ==
		{$past(horiz_sync_end_ff[HEND_BLANK_B5]), $past(horiz_blank_end_low)})
		else $error("blanking end value misformed");

	// Output tap for skews 0 and 3 in both modes and skew 2 in graphics mode
	chk_no_delay_path: assert property (sync_delay == 2'h0 && !text_mode
		|=> hretrace == $past(raw_retrace_ff))
		else $error("undelayed retrace mismatch");
	chk_text_delay_one: assert property (sync_delay == 2'h0 && text_mode
		|=> hretrace == $past(delay_pipe_ff[0]))
		else $error("text mode delay mismatch");
	chk_two_delay_tap: assert property (sync_delay == 2'h2 && !text_mode
		|=> hretrace == $past(delay_pipe_ff[1]))
		else $error("two clock delay mismatch");
	chk_max_delay_tap: assert property (sync_delay == 2'h3 && !text_mode
		|=> hretrace == $past(delay_pipe_ff[2]))
		else $error("three clock delay mismatch");
	chk_text_max_tap: assert property (sync_delay == 2'h3 && text_mode
		|=> hretrace == $past(delay_pipe_ff[3]))
		else $error("text mode longest delay mismatch");

	// Character and scan line counters, vertical total
	chk_hcount_clear: assert property (char_clk_en && line_start |=> hcount_ff == 8'h00)
		else $error("counter not cleared at line start");
	chk_hcount_step: assert property (char_clk_en && !line_start
		|=> hcount_ff == $past(hcount_ff) + 8'h01)
		else $error("counter did not advance");
	chk_hcount_hold: assert property (!char_clk_en |=> $stable(hcount_ff))
		else $error("counter moved without character clock");
	chk_vtotal_bits: assert property (!vt_ext_mode |=> vert_total[11:8] ==
		{2'h0, $past(vertical_overflow[OVF_VTOTAL_B9]), $past(vertical_overflow[OVF_VTOTAL_B8])})
		else $error("vertical total high bits wrong");
	chk_vtotal_ext: assert property (vt_ext_mode
		|=> vert_total[11:10] == $past(vt_ext_bits))
		else $error("extended vertical total bits wrong");
	chk_frame_wrap: assert property (char_clk_en && line_start && last_line
		|=> scan_line == 12'h000 && frame_start)
		else $error("frame did not wrap at total");

	// Register port
	chk_read_back: assert property (cpu_req.rd && !cpu_req.wr
		&& hit(cpu_req.index, IDX_HSYNC_END) |=> cpu_rdata == horiz_sync_end_ff)
		else $error("sync end read back wrong");
	chk_rdata_hold: assert property (!cpu_req.rd |=> $stable(cpu_rdata))
		else $error("read data changed without a read");

endmodule // vcht_timing

/* design/vcht_pkg.sv */
package vcht_pkg;

	// ----------------------------------------------------------------
	// Register indices behind the index/data port
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_HSYNC_START = 8'h04;
	localparam logic [7:0] IDX_HSYNC_END   = 8'h05;
	localparam logic [7:0] IDX_VTOTAL_LOW  = 8'h06;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_HSYNC_START = 8'h00;
	localparam logic [7:0] RST_HSYNC_END   = 8'h00;
	localparam logic [7:0] RST_VTOTAL_LOW  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HEND_BLANK_B5  = 7;  // Blanking end bit 5
	localparam int HEND_DELAY_HI  = 6;  // Sync delay field
	localparam int HEND_DELAY_LO  = 5;
	localparam int HEND_SYNC_HI   = 4;  // Sync end field
	localparam int OVF_VTOTAL_B9  = 5;  // Overflow bit giving total bit 9
	localparam int OVF_VTOTAL_B8  = 0;  // Overflow bit giving total bit 8

	// ----------------------------------------------------------------
	// Timing constants
	// ----------------------------------------------------------------
	localparam int          HCOUNT_W      = 8;
	localparam int          VCOUNT_W      = 12;
	localparam int          MAX_DELAY     = 4;   // Sync delay 3 plus text extra
	localparam logic [2:0]  TEXT_EXTRA    = 3'h1; // Extra text mode sync delay
	localparam logic [11:0] VTOTAL_ADJUST = 12'h001; // Lines = total + 2

	// Host access on the index/data port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} vcht_cpu_req_t;

endpackage

/* tb/vcht_monitor.sv */
`timescale 1ns/1ps
// Display side: times the retrace pulse from each line start
module vcht_monitor (
	input  wire logic       ref_clk,
	input  wire logic       char_clk_en,
	input  wire logic       line_start,
	input  wire logic       hretrace,
	output logic      [7:0] rise_at,
	output logic      [7:0] fall_at
);
	logic [7:0] cnt_ff;
	logic       prev_ff;
	// Cycles since line start, latched at each retrace edge
	always_ff @(posedge ref_clk) begin
		cnt_ff  <= (char_clk_en && line_start) ? 8'h00 : cnt_ff + 8'h01;
		prev_ff <= hretrace;
		if (hretrace && !prev_ff) rise_at <= cnt_ff;
		if (!hretrace && prev_ff) fall_at <= cnt_ff;
	end
endmodule // vcht_monitor

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import vcht_pkg::*;
	logic                ref_clk, reset_n, char_clk_en, line_start, text_mode;
	logic                vt_ext_mode;
	vcht_cpu_req_t       cpu_req;
	logic          [4:0] horiz_blank_end_low;
	logic          [7:0] vertical_overflow, cpu_rdata, hchar_count, rise_at, fall_at;
	logic          [1:0] vt_ext_bits;
	logic          [5:0] horiz_blank_end;
	logic         [11:0] vert_total, scan_line;
	logic                frame_start, hretrace;
	int                  failures, num_checks, cycles;

	vcht_timing dut (.ref_clk(ref_clk), .reset_n(reset_n), .cpu_req(cpu_req),
		.cpu_rdata(cpu_rdata), .char_clk_en(char_clk_en), .line_start(line_start),
		.text_mode(text_mode), .horiz_blank_end_low(horiz_blank_end_low),
		.vertical_overflow(vertical_overflow), .vt_ext_mode(vt_ext_mode),
		.vt_ext_bits(vt_ext_bits), .horiz_blank_end(horiz_blank_end),
		.vert_total(vert_total), .hchar_count(hchar_count), .scan_line(scan_line),
		.frame_start(frame_start), .hretrace(hretrace));
	vcht_monitor mon (.ref_clk(ref_clk), .char_clk_en(char_clk_en),
		.line_start(line_start), .hretrace(hretrace), .rise_at(rise_at), .fall_at(fall_at));

	// Clock and cycle ceiling
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			close_out();
		end
	end

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			failures++;
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk) #1;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		cpu_req = {2'b10, i, d};
		step(1);
		cpu_req = '0;
		step(1);
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] exp);
		cpu_req = {2'b01, i, 8'h00};
		step(1);
		cpu_req = '0;
		chk({4'h0, cpu_rdata}, {4'h0, exp});
		step(1);
	endtask
	task automatic pulse_line();
		line_start = 1'b1;
		step(1);
		line_start = 1'b0;
		step(1);
	endtask

	// Reset values, read back, unmapped index
	task automatic t_regs();
		rd(IDX_HSYNC_END, 8'h00);
		rd(IDX_VTOTAL_LOW, 8'h00);
		wr(IDX_HSYNC_START, 8'hA5);
		wr(IDX_HSYNC_END, 8'h5A);
		wr(8'h07, 8'hFF);
		rd(IDX_HSYNC_START, 8'hA5);
		rd(IDX_HSYNC_END, 8'h5A);
		rd(8'h07, 8'h00);
	endtask
	// Frame of total+2 lines, then wrap
	task automatic t_frame();
		wr(IDX_VTOTAL_LOW, 8'h02);
		repeat (3) pulse_line();
		chk(scan_line, 12'h003);
		chk({11'h000, frame_start}, 12'h000);
		line_start = 1'b1;
		step(1);
		line_start = 1'b0;
		chk(scan_line, 12'h000);
		chk({11'h000, frame_start}, 12'h001);
		step(1);
		chk({11'h000, frame_start}, 12'h000);
	endtask
	// Blanking end and vertical total assembly
	task automatic t_fields();
		wr(IDX_HSYNC_END, 8'h80);
		wr(IDX_VTOTAL_LOW, 8'h34);
		horiz_blank_end_low = 5'h15;
		vertical_overflow = 8'h21;
		step(2);
		chk({6'h00, horiz_blank_end}, 12'h035);
		chk(vert_total, 12'h334);
		vt_ext_mode = 1'b1;
		step(2);
		chk(vert_total, 12'hB34);
	endtask
	// Retrace edges for every delay code, text and graphics
	task automatic t_retrace();
		// One settling line clears any retrace left over from the earlier tests
		wr(IDX_HSYNC_START, 8'h0A);
		wr(IDX_HSYNC_END, 8'h0E);
		pulse_line();
		step(30);
		for (int k = 0; k < 8; k++) begin
			text_mode = k[2];
			wr(IDX_HSYNC_START, 8'h0A);
			wr(IDX_HSYNC_END, {1'b0, k[1:0], 5'h0E});
			pulse_line();
			step(30);
			chk({4'h0, rise_at}, 12'h00C + k[1:0] + k[2]);
			chk({4'h0, fall_at}, 12'h010 + k[1:0] + k[2]);
		end
	endtask
	// Character counter on a character clock of half rate
	task automatic t_slow();
		line_start = 1'b1;
		step(1);
		line_start = 1'b0;
		for (int n = 1; n <= 4; n++) begin
			char_clk_en = 1'b0;
			step(1);
			chk({4'h0, hchar_count}, 12'(n - 1));
			char_clk_en = 1'b1;
			step(1);
		end
		chk({4'h0, hchar_count}, 12'h004);
	endtask

	task automatic close_out();
		$display("failures=%0d num_checks=%0d", failures, num_checks);
		if (failures == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		cpu_req = '0;
		char_clk_en = 1'b1;
		line_start = 1'b0;
		text_mode = 1'b0;
		horiz_blank_end_low = 5'h00;
		vertical_overflow = 8'h00;
		vt_ext_mode = 1'b0;
		vt_ext_bits = 2'b10;
		step(2);
		reset_n = 1'b1;
		t_regs();
		t_frame();
		t_fields();
		t_retrace();
		t_slow();
		close_out();
	end
endmodule // testbench
